// *** core/lcdhcp_defs.vh ***
// shared constants of the lcd segment driver host command port
`ifndef LCDHCP_DEFS_VH
`define LCDHCP_DEFS_VH

// ==================================================================
// command codes and match masks
`define LCDHCP_CMD_DISP_MASK   8'hfe
`define LCDHCP_CMD_DISP        8'hae
`define LCDHCP_CMD_START_MASK  8'he0
`define LCDHCP_CMD_START       8'hc0
`define LCDHCP_CMD_PAGE_MASK   8'hfc
`define LCDHCP_CMD_PAGE        8'hb8
`define LCDHCP_CMD_COL_MASK    8'h80
`define LCDHCP_CMD_COL         8'h00
`define LCDHCP_CMD_ORDER       8'ha0
`define LCDHCP_CMD_STATIC      8'ha4
`define LCDHCP_CMD_DUTY        8'ha8
`define LCDHCP_CMD_SEL_MASK    8'hfe
`define LCDHCP_CMD_RMW         8'he0
`define LCDHCP_CMD_END         8'hee
`define LCDHCP_CMD_RESET       8'he2

// ==================================================================
// reset values and limits
`define LCDHCP_PAGE_RST        2'h3
`define LCDHCP_LINE_RST        5'h00
`define LCDHCP_COL_RST         7'h00
`define LCDHCP_COL_STOP        7'h50
`define LCDHCP_COL_LAST        7'h4f
`define LCDHCP_DATA_RST        8'h00

// ==================================================================
// status byte field positions
`define LCDHCP_ST_BUSY         7
`define LCDHCP_ST_ORDER        6
`define LCDHCP_ST_OFF          5
`define LCDHCP_ST_RESET        4

`endif

// *** core/lcdhcp_fifo.v ***
// shift-register fifo carrying committed ram writes
`timescale 1ns/1ps
`default_nettype none

module lcdhcp_fifo #(
  parameter WIDTH = 17,
  parameter DEPTH = 16,
  parameter CW    = 5
)(
  input  wire             clk,
  input  wire             srst,
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [CW-1:0]    count_reg;
  wire            push;
  wire            pop;
  wire [CW-1:0]   count_next;
  integer         i;

  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign count_next = count_reg + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
  // head always sits in slot 0, so the output is a plain flop
  assign out_data   = mem_reg[0];

  // ==================================================================
  // storage: shift down on pop, write at the first free slot
  always @(posedge clk)
  begin
    for (i = 0; i < DEPTH; i = i + 1)
    begin
      if (pop && i < DEPTH - 1)
        mem_reg[i] <= mem_reg[i + 1];
      if (push && i == count_reg - {{(CW-1){1'b0}}, pop})
        mem_reg[i] <= in_data;
    end
  end

  // ==================================================================
  // occupancy and honest full/empty flags
  always @(posedge clk)
  begin
    if (srst)
    begin
      count_reg <= {CW{1'b0}};
      out_valid <= 1'b0;
      in_ready  <= 1'b1;
    end
    else
    begin
      count_reg <= count_next;
      out_valid <= (count_next != {CW{1'b0}});
      in_ready  <= (count_next != DEPTH[CW-1:0]);
    end
  end

endmodule

`default_nettype wire

// *** core/lcdhcp_top.v ***
// host bus port and instruction decoder of the 80-output lcd segment driver
// How it works
// - data read returns the bus holder byte, fetched at the previous read or left by the last data write; column advances unless read-modify-write
// - order command bit 0 picks normal (0) or inverse (1) segment order
// - inverse order maps segment n to column 79-n, normal to column n
// - static drive command bit 0 forces all commons and whole display on
// - duty command bit 0 picks 1/16 (0) or 1/32 (1) duty
// - in read-modify-write, writes advance column, reads leave it
// - end command leaves read-modify-write and restores the saved column
// - soft reset sets start line to first, page to 3, ram untouched
// - display off plus static on gives power save: drive stopped, line clock ignored
// - display on or static off leaves power save
// - reset pin level picks 68-style (low) or 80-style (high) bus
// - chip select high disconnects and idles, yet soft reset still taken
// - select and direction decode ram read, ram write, status read, command
// - write data sits in a bus holder, committed on the next data write
`include "lcdhcp_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module lcdhcp_top #(
  parameter FIFO_DEPTH = 16
)(
  input  wire       CLK,
  input  wire       SRST,
  input  wire       CS_N,
  input  wire       DATA_COMMAND_SELECT,
  input  wire       ENABLE_RD_N,
  input  wire       RW_WR_N,
  input  wire [7:0] HOST_DATA_BUS_IN,
  output reg  [7:0] HOST_DATA_BUS_OUT,
  output reg        HOST_DATA_BUS_OE,
  input  wire       RESET_PIN_LEVEL,
  output wire       RAM_WR_VALID,
  input  wire       RAM_WR_READY,
  output wire [1:0] RAM_WR_PAGE,
  output wire [6:0] RAM_WR_COL,
  output wire [7:0] RAM_WR_DATA,
  output reg        RAM_RD_REQ,
  output reg  [1:0] RAM_RD_PAGE,
  output reg  [6:0] RAM_RD_COL,
  input  wire       RAM_RD_VALID,
  input  wire [7:0] RAM_RD_DATA,
  input  wire [6:0] SEG_INDEX,
  output reg  [6:0] SEG_COLUMN,
  output reg        DISPLAY_ON,
  output reg        STATIC_DRIVE,
  output reg        DUTY_32,
  output reg        SEG_INVERSE,
  output reg  [4:0] START_LINE,
  output reg  [1:0] PAGE_ADDR,
  output reg  [6:0] COLUMN_ADDR,
  output reg        RMW_ACTIVE,
  output reg        POWER_SAVE,
  output reg        LINE_CLOCK_ENABLE,
  output reg        SEG_HOLD_TOP,
  output reg        STANDBY,
  output reg        BUS_STYLE_80,
  output reg        BUSY
);

  // maps a segment output to the ram column that feeds it
  function [6:0] seg_to_col;
    input       inverse;
    input [6:0] seg;
    begin
      seg_to_col = inverse ? (`LCDHCP_COL_LAST - seg) : seg;
    end
  endfunction

  // column step that stops at the end marker instead of wrapping
  function [6:0] col_step;
    input [6:0] col;
    begin
      col_step = (col == `LCDHCP_COL_STOP) ? col : col + 7'h01;
    end
  endfunction

  // ==================================================================
  // pin synchronisers: first stage read only by the second
  reg  [11:0] pin_s1_reg;
  reg  [11:0] pin_s2_reg;
  wire        cs_n_s;
  wire        dcs_s;
  wire        e_rd_s;
  wire        rw_wr_s;
  wire [7:0]  data_s;
  wire        rst_lvl_s;
  always @(posedge CLK)
  begin
    pin_s1_reg <= {RESET_PIN_LEVEL, HOST_DATA_BUS_IN, RW_WR_N, ENABLE_RD_N, DATA_COMMAND_SELECT};
    pin_s2_reg <= pin_s1_reg;
  end
  assign dcs_s     = pin_s2_reg[0];
  assign e_rd_s    = pin_s2_reg[1];
  assign rw_wr_s   = pin_s2_reg[2];
  assign data_s    = pin_s2_reg[10:3];
  assign rst_lvl_s = pin_s2_reg[11];
  // chip select in its own pair so it reads clearly
  reg cs_s1_reg;
  reg cs_s2_reg;
  always @(posedge CLK)
  begin
    cs_s1_reg <= CS_N;
    cs_s2_reg <= cs_s1_reg;
  end
  assign cs_n_s = cs_s2_reg;

  // ==================================================================
  // strobe decode for both bus styles
  wire rd_act;
  wire wr_act;
  reg  rd_act_reg;
  reg  wr_act_reg;
  reg  [7:0] wdata_reg;
  wire rd_start;
  wire wr_end;
  assign rd_act   = BUS_STYLE_80 ? ~e_rd_s : (e_rd_s & rw_wr_s);
  assign wr_act   = BUS_STYLE_80 ? ~rw_wr_s : (e_rd_s & ~rw_wr_s);
  assign rd_start = rd_act & ~rd_act_reg & ~cs_n_s;
  // writes are taken at the trailing edge, even unselected, so soft reset gets through
  assign wr_end   = ~wr_act & wr_act_reg;

  always @(posedge CLK)
  begin
    if (SRST)
    begin
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      wdata_reg  <= `LCDHCP_DATA_RST;
    end
    else
    begin
      rd_act_reg <= rd_act;
      wr_act_reg <= wr_act;
      if (wr_act)
        wdata_reg <= data_s;
    end
  end

  // access kinds; the select is sampled at the strobe edge
  wire sel_ok     = ~cs_n_s;
  wire ram_rd     = rd_start & dcs_s;
  wire stat_rd    = rd_start & ~dcs_s;
  wire ram_wr     = wr_end & dcs_s & sel_ok;
  wire cmd_wr     = wr_end & ~dcs_s & sel_ok;
  wire soft_reset = wr_end & ~dcs_s & (wdata_reg == `LCDHCP_CMD_RESET);
  wire sel_bit    = wdata_reg[0];
  wire is_disp    = cmd_wr & ((wdata_reg & `LCDHCP_CMD_DISP_MASK) == `LCDHCP_CMD_DISP);
  wire is_static  = cmd_wr & ((wdata_reg & `LCDHCP_CMD_SEL_MASK) == `LCDHCP_CMD_STATIC);
  wire is_order   = cmd_wr & ((wdata_reg & `LCDHCP_CMD_SEL_MASK) == `LCDHCP_CMD_ORDER);
  wire is_duty    = cmd_wr & ((wdata_reg & `LCDHCP_CMD_SEL_MASK) == `LCDHCP_CMD_DUTY);
  wire is_start   = cmd_wr & ((wdata_reg & `LCDHCP_CMD_START_MASK) == `LCDHCP_CMD_START);
  wire is_page    = cmd_wr & ((wdata_reg & `LCDHCP_CMD_PAGE_MASK) == `LCDHCP_CMD_PAGE);
  wire is_col     = cmd_wr & ((wdata_reg & `LCDHCP_CMD_COL_MASK) == `LCDHCP_CMD_COL);
  wire is_rmw     = cmd_wr & (wdata_reg == `LCDHCP_CMD_RMW);
  wire is_end     = cmd_wr & (wdata_reg == `LCDHCP_CMD_END);

  // ==================================================================
  // bus holder and commit path into the write fifo
  reg  [7:0] holder_reg;
  reg        pend_reg;
  reg  [8:0] pend_addr_reg;
  reg  [7:0] pend_data_reg;
  wire       fifo_ready;
  wire [16:0] fifo_out;
  reg        reset_flag_reg;
  reg  [6:0] saved_col_reg;
  // the previous write leaves the holder when the next data write arrives
  wire commit = ram_wr & pend_reg;
  lcdhcp_fifo #(
    .WIDTH (17),
    .DEPTH (FIFO_DEPTH),
    .CW    (5)
  ) u_fifo (
    .clk       (CLK),
    .srst      (SRST),
    .in_valid  (commit),
    .in_ready  (fifo_ready),
    .in_data   ({pend_addr_reg, pend_data_reg}),
    .out_valid (RAM_WR_VALID),
    .out_ready (RAM_WR_READY),
    .out_data  (fifo_out)
  );

  assign RAM_WR_PAGE = fifo_out[16:15];
  assign RAM_WR_COL  = fifo_out[14:8];
  assign RAM_WR_DATA = fifo_out[7:0];
  // holder keeps last write data or the byte fetched for the next read
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      holder_reg    <= `LCDHCP_DATA_RST;
      pend_reg      <= 1'b0;
      pend_addr_reg <= 9'h000;
      pend_data_reg <= `LCDHCP_DATA_RST;
    end
    else if (ram_wr)
    begin
      holder_reg    <= wdata_reg;
      pend_reg      <= 1'b1;
      pend_addr_reg <= {PAGE_ADDR, COLUMN_ADDR};
      pend_data_reg <= wdata_reg;
    end
    else if (RAM_RD_VALID)
      holder_reg <= RAM_RD_DATA;
  end

  // ==================================================================
  // host read data: reads see the holder, so the first read is stale
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      HOST_DATA_BUS_OUT <= `LCDHCP_DATA_RST;
      HOST_DATA_BUS_OE  <= 1'b0;
      RAM_RD_REQ        <= 1'b0;
      RAM_RD_PAGE       <= `LCDHCP_PAGE_RST;
      RAM_RD_COL        <= `LCDHCP_COL_RST;
    end
    else
    begin
      HOST_DATA_BUS_OE <= rd_act & ~cs_n_s;
      RAM_RD_REQ       <= ram_rd;
      if (ram_rd)
      begin
        HOST_DATA_BUS_OUT <= holder_reg;
        RAM_RD_PAGE       <= PAGE_ADDR;
        RAM_RD_COL        <= COLUMN_ADDR;
      end
      else if (stat_rd)
      begin
        HOST_DATA_BUS_OUT <= 8'h00;
        HOST_DATA_BUS_OUT[`LCDHCP_ST_BUSY]  <= BUSY;
        HOST_DATA_BUS_OUT[`LCDHCP_ST_ORDER] <= ~SEG_INVERSE;
        HOST_DATA_BUS_OUT[`LCDHCP_ST_OFF]   <= ~DISPLAY_ON;
        HOST_DATA_BUS_OUT[`LCDHCP_ST_RESET] <= reset_flag_reg;
      end
    end
  end

  // ==================================================================
  // mode registers and address pointers
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      DISPLAY_ON     <= 1'b0;
      STATIC_DRIVE   <= 1'b0;
      DUTY_32        <= 1'b1;
      SEG_INVERSE    <= 1'b0;
      START_LINE     <= `LCDHCP_LINE_RST;
      PAGE_ADDR      <= `LCDHCP_PAGE_RST;
      COLUMN_ADDR    <= `LCDHCP_COL_RST;
      RMW_ACTIVE     <= 1'b0;
      saved_col_reg  <= `LCDHCP_COL_RST;
      reset_flag_reg <= 1'b1;
    end
    else
    begin
      // the reset flag marks one initialisation cycle
      reset_flag_reg <= soft_reset;
      if (soft_reset)
      begin
        START_LINE <= `LCDHCP_LINE_RST;
        PAGE_ADDR  <= `LCDHCP_PAGE_RST;
      end
      if (is_disp)
        DISPLAY_ON <= sel_bit;
      if (is_static)
        STATIC_DRIVE <= sel_bit;
      if (is_order)
        SEG_INVERSE <= sel_bit;
      if (is_duty)
        DUTY_32 <= sel_bit;
      if (is_start)
        START_LINE <= wdata_reg[4:0];
      if (is_page)
        PAGE_ADDR <= wdata_reg[1:0];
      // column pointer: last matching event wins
      if (ram_rd && !RMW_ACTIVE)
        COLUMN_ADDR <= col_step(COLUMN_ADDR);
      if (ram_wr)
        COLUMN_ADDR <= col_step(COLUMN_ADDR);
      if (is_col)
        COLUMN_ADDR <= wdata_reg[6:0];
      if (is_rmw)
      begin
        RMW_ACTIVE    <= 1'b1;
        saved_col_reg <= COLUMN_ADDR;
      end
      if (is_end)
      begin
        RMW_ACTIVE  <= 1'b0;
        COLUMN_ADDR <= saved_col_reg;
      end
    end
  end

  // ==================================================================
  // display side status and power save
  // power save follows the two mode bits, so either command releases it
  wire psave = ~DISPLAY_ON & STATIC_DRIVE;
  always @(posedge CLK)
  begin
    if (SRST)
    begin
      POWER_SAVE        <= 1'b0;
      LINE_CLOCK_ENABLE <= 1'b1;
      SEG_HOLD_TOP      <= 1'b0;
      STANDBY           <= 1'b0;
      BUS_STYLE_80      <= 1'b0;
      BUSY              <= 1'b1;
      SEG_COLUMN        <= `LCDHCP_COL_RST;
    end
    else
    begin
      POWER_SAVE        <= psave;
      LINE_CLOCK_ENABLE <= ~psave;
      SEG_HOLD_TOP      <= psave;
      STANDBY           <= cs_n_s;
      BUS_STYLE_80      <= rst_lvl_s;
      // busy while initialising or when the write path cannot take a commit
      BUSY              <= reset_flag_reg | ~fifo_ready;
      SEG_COLUMN        <= seg_to_col(SEG_INVERSE, SEG_INDEX);
    end
  end

endmodule

`default_nettype wire

// *** dv/lcdhcp_ram.sv ***
// display ram model standing behind the host command port
`timescale 1ns/1ps
`default_nettype none
module lcdhcp_ram (
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic       wr_valid,
  output logic            wr_ready,
  input  wire logic [1:0] wr_page,
  input  wire logic [6:0] wr_col,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_req,
  input  wire logic [1:0] rd_page,
  input  wire logic [6:0] rd_col,
  output logic            rd_valid,
  output logic [7:0]      rd_data
);
  // ==================================================================
  // storage and answers
  logic [7:0] mem [0:3][0:127];
  // stall lets the fifo fill up behind a slow ram
  assign wr_ready = !stall;
  // read data between answers flips every cycle, so a stale sample shows up
  always @(posedge clk)
  begin
    if (wr_valid && wr_ready)
      mem[wr_page][wr_col] <= wr_data;
    rd_valid <= rd_req;
    rd_data  <= rd_req ? mem[rd_page][rd_col] : ~rd_data;
  end
endmodule
`default_nettype wire

// *** dv/lcdhcp_chk.sv ***
// concurrent checks on the outputs of the host command port
`timescale 1ns/1ps
`default_nettype none
module lcdhcp_chk (
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic       RAM_WR_VALID,
  input wire logic       RAM_WR_READY,
  input wire logic [1:0] RAM_WR_PAGE,
  input wire logic [6:0] RAM_WR_COL,
  input wire logic [7:0] RAM_WR_DATA,
  input wire logic       RAM_RD_REQ,
  input wire logic [1:0] RAM_RD_PAGE,
  input wire logic [6:0] RAM_RD_COL,
  input wire logic [6:0] SEG_INDEX,
  input wire logic [6:0] SEG_COLUMN,
  input wire logic       DISPLAY_ON,
  input wire logic       STATIC_DRIVE,
  input wire logic       SEG_INVERSE,
  input wire logic [1:0] PAGE_ADDR,
  input wire logic [6:0] COLUMN_ADDR,
  input wire logic       RMW_ACTIVE,
  input wire logic       POWER_SAVE,
  input wire logic       LINE_CLOCK_ENABLE,
  input wire logic       SEG_HOLD_TOP
);
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  logic [6:0] saved_reg;
  // ==================================================================
  // column seen when read-modify-write starts
  always @(posedge CLK)
  begin
    if ($rose(RMW_ACTIVE))
      saved_reg <= COLUMN_ADDR;
  end
  // ==================================================================
  // properties; power save may lag its mode bits by one register
  AST_PSAVE_ON: assert property (!DISPLAY_ON && STATIC_DRIVE |-> ##[0:1] POWER_SAVE)
    else $error("power save not entered");
  AST_PSAVE_OFF: assert property (DISPLAY_ON || !STATIC_DRIVE |-> ##[0:1] !POWER_SAVE)
    else $error("power save not left");
  AST_PSAVE_PINS: assert property (POWER_SAVE |-> SEG_HOLD_TOP && !LINE_CLOCK_ENABLE)
    else $error("drive not stopped in power save");
  AST_SEG_MAP: assert property ($past(SEG_INDEX) < 7'h50 && !$past(SRST) |->
    SEG_COLUMN == ($past(SEG_INVERSE) ? 7'h4f - $past(SEG_INDEX) : $past(SEG_INDEX)))
    else $error("segment column wrong");
  AST_RD_PULSE: assert property (RAM_RD_REQ |=> !RAM_RD_REQ)
    else $error("read request longer than one cycle");
  AST_RD_PAGE: assert property (RAM_RD_REQ |-> RAM_RD_PAGE == PAGE_ADDR)
    else $error("read page differs from pointer");
  AST_RD_STEP: assert property (RAM_RD_REQ && !RMW_ACTIVE && RAM_RD_COL < 7'h50 |->
    ##[0:1] COLUMN_ADDR == RAM_RD_COL + 7'h01)
    else $error("column not advanced by read");
  AST_RD_KEEP: assert property (RAM_RD_REQ && RMW_ACTIVE |-> (COLUMN_ADDR == RAM_RD_COL) [*2])
    else $error("column moved by read in rmw");
  AST_WR_HOLD: assert property (RAM_WR_VALID && !RAM_WR_READY |=>
    RAM_WR_VALID && $stable({RAM_WR_PAGE, RAM_WR_COL, RAM_WR_DATA}))
    else $error("fifo head changed while stalled");
  AST_COL_STOP: assert property (COLUMN_ADDR <= 7'h50)
    else $error("column beyond stop value");
  AST_RMW_BACK: assert property ($fell(RMW_ACTIVE) |-> COLUMN_ADDR == saved_reg)
    else $error("column not restored at end");
  COV_PSAVE: cover property (POWER_SAVE);
  COV_STALL: cover property (RAM_WR_VALID && !RAM_WR_READY);
  COV_RMW: cover property ($fell(RMW_ACTIVE));
endmodule
bind lcdhcp_top lcdhcp_chk u_chk (
  .CLK, .SRST, .RAM_WR_VALID, .RAM_WR_READY, .RAM_WR_PAGE, .RAM_WR_COL, .RAM_WR_DATA, .RAM_RD_REQ,
  .RAM_RD_PAGE, .RAM_RD_COL, .SEG_INDEX, .SEG_COLUMN, .DISPLAY_ON, .STATIC_DRIVE, .SEG_INVERSE,
  .PAGE_ADDR, .COLUMN_ADDR, .RMW_ACTIVE, .POWER_SAVE, .LINE_CLOCK_ENABLE, .SEG_HOLD_TOP
);
`default_nettype wire

// *** dv/lcdhcp_top_bench.sv ***
// self-checking bench of the host command port
`timescale 1ns/1ps
`default_nettype none
module lcdhcp_top_bench;
  logic       clk, srst, cs_n, a0, rd, wr, lvl, stall, csv;
  logic [7:0] din, q;
  logic [6:0] seg;
  wire        oe, wv, wrdy, rreq, rv, don, stat, duty, inv, rmw, psave, lce, segtop, stby, sty80, busy;
  wire  [7:0] dout, wd, rdat;
  wire  [6:0] wcol, rcol, segc, col;
  wire  [4:0] sline;
  wire  [1:0] wpg, rpg, page;
  int         err_count, checked;
  logic [7:0] code [10] = '{8'ha1, 8'ha0, 8'ha8, 8'ha9, 8'haf, 8'ha5, 8'hae, 8'haf, 8'hae, 8'ha4};
  logic [4:0] expv [10] = '{5'h06, 5'h04, 5'h00, 5'h04, 5'h14, 5'h1c, 5'h0d, 5'h1c, 5'h0d, 5'h04};
  lcdhcp_top dut (
    .CLK(clk), .SRST(srst), .CS_N(cs_n), .DATA_COMMAND_SELECT(a0), .ENABLE_RD_N(rd), .RW_WR_N(wr),
    .HOST_DATA_BUS_IN(din), .HOST_DATA_BUS_OUT(dout), .HOST_DATA_BUS_OE(oe), .RESET_PIN_LEVEL(lvl),
    .RAM_WR_VALID(wv), .RAM_WR_READY(wrdy), .RAM_WR_PAGE(wpg), .RAM_WR_COL(wcol), .RAM_WR_DATA(wd),
    .RAM_RD_REQ(rreq), .RAM_RD_PAGE(rpg), .RAM_RD_COL(rcol), .RAM_RD_VALID(rv), .RAM_RD_DATA(rdat),
    .SEG_INDEX(seg), .SEG_COLUMN(segc), .DISPLAY_ON(don), .STATIC_DRIVE(stat), .DUTY_32(duty),
    .SEG_INVERSE(inv), .START_LINE(sline), .PAGE_ADDR(page), .COLUMN_ADDR(col), .RMW_ACTIVE(rmw),
    .POWER_SAVE(psave), .LINE_CLOCK_ENABLE(lce), .SEG_HOLD_TOP(segtop), .STANDBY(stby),
    .BUS_STYLE_80(sty80), .BUSY(busy)
  );
  lcdhcp_ram ram (
    .clk(clk), .stall(stall), .wr_valid(wv), .wr_ready(wrdy), .wr_page(wpg), .wr_col(wcol),
    .wr_data(wd), .rd_req(rreq), .rd_page(rpg), .rd_col(rcol), .rd_valid(rv), .rd_data(rdat)
  );
  // ==================================================================
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobe held five cycles, then six idle so the synchronisers settle
  task automatic acc(input logic c, input logic is_rd, input logic [7:0] d);
    cs_n <= csv;
    a0   <= c;
    din  <= d;
    @(posedge clk);
    rd <= lvl ? !is_rd : 1'b1;
    wr <= is_rd;
    repeat (5) @(posedge clk);
    q = dout;
    chk({7'h0, oe}, {7'h0, is_rd && !csv});
    rd <= lvl;
    wr <= 1'b1;
    repeat (6) @(posedge clk); // idle gap between accesses
  endtask
  task automatic cmd(input logic [7:0] d);
    acc(1'b0, 1'b0, d);
  endtask
  task automatic put(input logic [7:0] d);
    acc(1'b1, 1'b0, d);
  endtask
  task automatic get;
    acc(1'b1, 1'b1, 8'h00);
  endtask
  task automatic st_rd;
    acc(1'b0, 1'b1, 8'h00);
  endtask
  task automatic conclude;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==================================================================
  // scenarios
  task automatic t_reset;
    chk({don, stat, duty, inv, rmw, psave, lce, busy}, 8'h22);
    chk({sline, 1'b0, page}, 8'h03);
    chk({sty80, col}, 8'h80);
    st_rd;
    chk(q, 8'h60);
  endtask
  task automatic t_ram;
    cmd(8'hb8);
    cmd(8'h05);
    put(8'h11);
    put(8'h22);
    put(8'h33);
    chk({1'b0, col}, 8'h08);
    chk(ram.mem[0][5], 8'h11);
    chk(ram.mem[0][6], 8'h22);
    cmd(8'h05);
    get; // discarded read after the address set
    get;
    chk(q, 8'h11);
    get;
    chk(q, 8'h22);
    chk({1'b0, col}, 8'h08);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 10; i++)
    begin
      cmd(code[i]);
      chk({3'h0, don, stat, duty, inv, psave}, {3'h0, expv[i]});
      chk({1'b0, segc}, expv[i][1] ? 8'h4c : 8'h03);
      st_rd;
      chk(q, {1'b0, !expv[i][1], !expv[i][4], 5'h0});
    end
    cmd(8'ha8); // host sets the duty of its master common driver, 1/16 here
    chk({7'h0, duty}, 8'h00);
  endtask
  task automatic t_rmw;
    cmd(8'h10);
    cmd(8'he0);
    put(8'ha5);
    put(8'h5a);
    chk({rmw, col}, 8'h92);
    get;
    chk({rmw, col}, 8'h92);
    cmd(8'hee); // no column set while the mode is on
    chk({rmw, col}, 8'h10);
  endtask
  task automatic t_soft;
    cmd(8'hc5);
    cmd(8'hb9);
    chk({sline, 1'b0, page}, 8'h29);
    csv = 1'b1;
    cmd(8'haf);
    chk({5'h0, stby, don, wv}, 8'h04);
    cmd(8'he2);
    chk({sline, 1'b0, page}, 8'h03);
    csv = 1'b0;
  endtask
  task automatic t_fill;
    stall <= 1'b1;
    cmd(8'hb8);
    cmd(8'h00);
    for (int i = 0; i < 16; i++)
      put(8'(i));
    chk({6'h0, busy, wv}, 8'h03);
    stall <= 1'b0;
    repeat (24) @(posedge clk);
    chk({6'h0, busy, wv}, 8'h00);
    for (int i = 0; i < 15; i++)
      chk(ram.mem[0][i], 8'(i));
    chk(ram.mem[0][17], 8'h5a);
    cmd(8'h4f);
    put(8'h01);
    put(8'h02);
    chk({1'b0, col}, 8'h50);
  endtask
  task automatic t_68;
    cs_n <= 1'b1;
    lvl  <= 1'b0;
    rd   <= 1'b0;
    repeat (6) @(posedge clk);
    chk({7'h0, sty80}, 8'h00);
    cmd(8'ha1);
    chk({7'h0, inv}, 8'h01);
    st_rd;
    chk(q, 8'h20);
  endtask
  // ==================================================================
  // clock, watchdog and main sequence
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude;
  end
  // hardware reset at power-up, bus idle in the 80 style
  initial
  begin
    srst  <= 1'b1;
    cs_n  <= 1'b1;
    a0    <= 1'b0;
    rd    <= 1'b1;
    wr    <= 1'b1;
    lvl   <= 1'b1;
    stall <= 1'b0;
    din   <= 8'h00;
    seg   <= 7'h03;
    csv = 1'b0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset;
    t_ram;
    t_modes;
    t_rmw;
    t_soft;
    t_fill;
    t_68;
    conclude;
  end
endmodule
`default_nettype wire
